// file: rtl/usr_sense_enable.sv
// User sense latches, user enable outputs and mode register behind an APB slave.
// Assumes asynchronous sense pins and a 100 MHz pclk with active-low async reset.
//
// What this block does
// - Reset clears every register, including sense and enable bits, except stop_mode, which it sets, and the bus state, which goes to USR_IDLE.
// - Reset forces the mode run bit to zero, giving stop mode.
// - Sense bit sets after its input stays high at least 160 ns.
// - Latched sense bit stays set until cleared over the bus.
// - Each enable output follows its enable bit.
`timescale 1ns/100ps
`include "usr_consts.svh"

module usr_sense_enable
  import usr_pkg::*;
#(
  parameter int SENSE_CYC = `USR_SENSE_CYC
)
(
  input  wire logic        pclk,              // Bus and core clock, 100 MHz.
  input  wire logic        presetn,           // Asynchronous reset, active low.
  input  wire logic        psel,              // APB select.
  input  wire logic        penable,           // APB access phase.
  input  wire logic        pwrite,            // APB write when high.
  input  wire logic [11:0] paddr,             // APB byte address.
  input  wire logic [31:0] pwdata,            // APB write data.
  output logic      [31:0] prdata,            // APB read data.
  output logic             pready,            // APB ready.
  output logic             pslverr,           // APB error for unmapped address.
  input  wire logic        user_sense_in_0,   // Asynchronous sense pin 0.
  input  wire logic        user_sense_in_1,   // Asynchronous sense pin 1.
  output logic             user_enable_out_0, // Enable pin 0.
  output logic             user_enable_out_1, // Enable pin 1.
  output logic             stop_mode,         // High while the device is in stop mode.
  output logic             irq                // Level interrupt, unmasked status set.
);

  // The qualifier counters are eight bits wide, so longer qualification is refused.
  if (SENSE_CYC < 1 || SENSE_CYC > 255)
  begin : g_bad_sense_cyc
    $error("SENSE_CYC out of range");
  end

  // --------------------------------------------------------------------------
  // Sense pin synchronisers and qualifiers
  // --------------------------------------------------------------------------
  logic [2:0] sync0_r, sync1_r, sync0_nxt, sync1_nxt;
  logic [7:0] cnt_r [2];
  logic [7:0] cnt_nxt [2];
  logic [1:0] qual;
  logic [1:0] lvl;
  logic [1:0] lvl_r;

  always_comb
  begin
    sync0_nxt = {sync0_r[1:0], user_sense_in_0};
    sync1_nxt = {sync1_r[1:0], user_sense_in_1};
    // A change counts only once the second and third stages agree; while they differ
    // the last agreed level is kept, so one unsettled sample cannot cut a count short.
    lvl[0] = (sync0_r[1] == sync0_r[2]) ? sync0_r[1] : lvl_r[0];
    lvl[1] = (sync1_r[1] == sync1_r[2]) ? sync1_r[1] : lvl_r[1];
    for (int i = 0; i < 2; i++)
    begin
      qual[i] = 1'b0;
      cnt_nxt[i] = 8'h00;
      if (lvl[i])
      begin
        if (cnt_r[i] == 8'(SENSE_CYC - 1))
        begin
          qual[i] = 1'b1;
          cnt_nxt[i] = cnt_r[i];
        end
        else
          cnt_nxt[i] = cnt_r[i] + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync0_r  <= 3'h0;
      sync1_r  <= 3'h0;
      cnt_r[0] <= 8'h00;
      cnt_r[1] <= 8'h00;
      lvl_r    <= 2'h0;
    end
    else
    begin
      sync0_r  <= sync0_nxt;
      sync1_r  <= sync1_nxt;
      cnt_r[0] <= cnt_nxt[0];
      cnt_r[1] <= cnt_nxt[1];
      lvl_r    <= lvl;
    end
  end

  // --------------------------------------------------------------------------
  // Registers and APB slave
  // --------------------------------------------------------------------------
  usr_apb_req_t   req;
  usr_bus_state_t st_r, st_nxt;
  logic [3:0]  ureg_r, ureg_nxt;
  logic [7:0]  mode_r, mode_nxt;
  logic [1:0]  stat_r, stat_nxt, mask_r, mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        rdy_r, rdy_nxt, err_r, err_nxt, irq_nxt;
  logic        acc, wr, rd, hit;

  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

  always_comb
  begin
    acc = psel & penable & (st_r == USR_ACCESS);
    wr  = acc & req.write;
    rd  = acc & ~req.write;
    hit = (req.addr == `USR_OFS_UREG) || (req.addr == `USR_OFS_MODE) ||
          (req.addr == `USR_OFS_INT_STAT) || (req.addr == `USR_OFS_INT_MASK);
    st_nxt = st_r;
    unique case (st_r)
      USR_IDLE:   if (psel && !penable) st_nxt = USR_ACCESS;
      USR_ACCESS: if (penable) st_nxt = USR_DONE;
      USR_DONE:   st_nxt = USR_IDLE;
      default:    st_nxt = USR_IDLE;
    endcase
    rdy_nxt   = acc;
    err_nxt   = acc & ~hit;
    rdata_nxt = 32'h0000_0000;
    ureg_nxt  = ureg_r;
    mode_nxt  = mode_r;
    mask_nxt  = mask_r;
    stat_nxt  = stat_r;
    if (wr && req.addr == `USR_OFS_UREG)
    begin
      // Writing one to a sense bit leaves it alone; zero clears it.
      ureg_nxt[`USR_SNS0] = ureg_r[`USR_SNS0] & req.wdata[`USR_SNS0];
      ureg_nxt[`USR_SNS1] = ureg_r[`USR_SNS1] & req.wdata[`USR_SNS1];
      ureg_nxt[`USR_ENA0] = req.wdata[`USR_ENA0];
      ureg_nxt[`USR_ENA1] = req.wdata[`USR_ENA1];
    end
    if (wr && req.addr == `USR_OFS_MODE)
      mode_nxt = req.wdata[7:0];
    if (wr && req.addr == `USR_OFS_INT_MASK)
      mask_nxt = req.wdata[1:0];
    if (rd)
    begin
      unique case (req.addr)
        `USR_OFS_UREG:     rdata_nxt = {28'h0, ureg_r};
        `USR_OFS_MODE:     rdata_nxt = {24'h0, mode_r};
        `USR_OFS_INT_STAT: rdata_nxt = {30'h0, stat_r};
        `USR_OFS_INT_MASK: rdata_nxt = {30'h0, mask_r};
        default:           rdata_nxt = 32'h0000_0000;
      endcase
      if (req.addr == `USR_OFS_INT_STAT)
        stat_nxt = 2'b00;
    end
    // A newly qualified sense wins over a clear in the same cycle.
    ureg_nxt[`USR_SNS0] = ureg_nxt[`USR_SNS0] | qual[0];
    ureg_nxt[`USR_SNS1] = ureg_nxt[`USR_SNS1] | qual[1];
    stat_nxt = stat_nxt | (qual & ~ureg_r[1:0]);
    irq_nxt  = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r              <= USR_IDLE;
      ureg_r            <= `USR_UREG_RST;
      mode_r            <= `USR_MODE_RST;
      stat_r            <= 2'b00;
      mask_r            <= 2'b00;
      rdata_r           <= 32'h0000_0000;
      rdy_r             <= 1'b0;
      err_r             <= 1'b0;
      irq               <= 1'b0;
      user_enable_out_0 <= 1'b0;
      user_enable_out_1 <= 1'b0;
      stop_mode         <= 1'b1;
    end
    else
    begin
      st_r              <= st_nxt;
      ureg_r            <= ureg_nxt;
      mode_r            <= mode_nxt;
      stat_r            <= stat_nxt;
      mask_r            <= mask_nxt;
      rdata_r           <= rdata_nxt;
      rdy_r             <= rdy_nxt;
      err_r             <= err_nxt;
      irq               <= irq_nxt;
      user_enable_out_0 <= ureg_nxt[`USR_ENA0];
      user_enable_out_1 <= ureg_nxt[`USR_ENA1];
      stop_mode         <= ~mode_nxt[`USR_MODE_RUN];
    end
  end

  // The answer is registered, so pready rises one cycle into the access phase.
  assign prdata  = rdata_r;
  assign pready  = rdy_r;
  assign pslverr = err_r;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sense_sets_bit_a: assert property (qual[0] |=> ureg_r[`USR_SNS0])
    else $error("sense bit 0 not set after qualified input");
  // The qualified level must already have been high SENSE_CYC cycles before the bit rises.
  sense_needs_time_a: assert property ($rose(ureg_r[`USR_SNS1]) |->
      $past(lvl[1], SENSE_CYC))
    else $error("sense bit 1 set without held input");
  sense_sticky_a: assert property (ureg_r[0] && !(wr && req.addr == `USR_OFS_UREG) |=>
      ureg_r[0])
    else $error("sense bit 0 dropped without a bus write");
  clear_zero_a: assert property (wr && req.addr == `USR_OFS_UREG && !req.wdata[0] &&
      !qual[0] |=> !ureg_r[0])
    else $error("write of zero did not clear sense bit 0");
  set_wins_a: assert property (wr && req.addr == `USR_OFS_UREG && qual[1] |=> ureg_r[1])
    else $error("clear beat a new sense latch");
  enable_follow_a: assert property (user_enable_out_0 == ureg_r[`USR_ENA0] &&
      user_enable_out_1 == ureg_r[`USR_ENA1])
    else $error("enable output differs from enable bit");
  stop_follow_a: assert property (stop_mode == !mode_r[`USR_MODE_RUN])
    else $error("stop mode differs from mode bit");
  ready_one_a: assert property (pready |=> !pready)
    else $error("pready held more than one cycle");
  post_reset_a: assert property (@(posedge pclk) $rose(presetn) |->
      ureg_r == 4'h0 && !mode_r[0] && stat_r == 2'b00)
    else $error("registers not clear after reset");

  cov_sense0_c: cover property (qual[0] ##1 ureg_r[0]);
  cov_clear_c:  cover property (wr && req.addr == `USR_OFS_UREG ##1 !ureg_r[0]);
  cov_irq_c:    cover property ($rose(irq));
  cov_run_c:    cover property ($fell(stop_mode));

endmodule

// file: common/usr_consts.svh
// Offsets, field positions, reset values and timing counts of the user sense/enable block.
// Assumes a 100 MHz pclk and APB byte addressing with one register per aligned word.
`ifndef USR_CONSTS_SVH
`define USR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define USR_OFS_UREG     12'h000
`define USR_OFS_MODE     12'h004
`define USR_OFS_INT_STAT 12'h008
`define USR_OFS_INT_MASK 12'h00c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define USR_SNS0         0
`define USR_SNS1         1
`define USR_ENA0         2
`define USR_ENA1         3
`define USR_MODE_RUN     0

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define USR_UREG_RST     4'h0
`define USR_MODE_RST     8'h00
`define USR_SENSE_NS     160
`define USR_CLK_NS       10
`define USR_SENSE_CYC    ((`USR_SENSE_NS + `USR_CLK_NS - 1) / `USR_CLK_NS)

`endif

// file: common/usr_pkg.sv
// Types shared by the user sense/enable block.
// Assumes the constants header is included by the design file.
package usr_pkg;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
  } usr_apb_req_t;

  typedef enum logic [2:0] {
    USR_IDLE   = 3'b001,
    USR_ACCESS = 3'b010,
    USR_DONE   = 3'b100
  } usr_bus_state_t;

endpackage

// file: verification/usr_user_side.sv
// Model of the user logic beside the block: drives the sense pins, sees the enable pins.
// Assumes the bench pclk; pins change only just after a rising edge.
`timescale 1ns/100ps
module usr_user_side
(
  input  wire logic pclk,    // Core clock.
  output logic      sense_0, // Sense pin 0 drive.
  output logic      sense_1, // Sense pin 1 drive.
  input  wire logic en_0,    // Enable pin 0 as seen here.
  input  wire logic en_1     // Enable pin 1 as seen here.
);
  // Sense lines idle low, so a deasserted pin never floats.
  initial
  begin
    sense_0 = 1'b0;
    sense_1 = 1'b0;
  end

  task automatic level(input int idx, input logic v);
    @(posedge pclk);
    if (idx == 0) sense_0 <= v;
    else sense_1 <= v;
  endtask

  task automatic pulse(input int idx, input int cyc);
    level(idx, 1'b1);
    repeat (cyc - 1) @(posedge pclk);
    level(idx, 1'b0);
  endtask
endmodule

// file: verification/user_sense_enable_reset_test.sv
// Self-checking bench for the user sense/enable block over APB.
// Assumes the user side model and a shortened sense qualification count.
`timescale 1ns/100ps
`include "usr_consts.svh"
`define CHK(nm, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("wrong value %s exp %h got %h", nm, exp, got); \
    end \
  end
module user_sense_enable_reset_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        s0;
  logic        s1;
  logic        e0;
  logic        e1;
  logic        stop_mode;
  logic        irq;
  logic [31:0] rdat;
  logic        rerr;
  int          error_cnt = 0;
  int          n_tests = 0;

  always #5 pclk = ~pclk;

  usr_sense_enable #(.SENSE_CYC(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .user_sense_in_0(s0), .user_sense_in_1(s1),
    .user_enable_out_0(e0), .user_enable_out_1(e1), .stop_mode(stop_mode), .irq(irq));
  usr_user_side far (.pclk(pclk), .sense_0(s0), .sense_1(s1), .en_0(e0), .en_1(e1));

  // ----------------------------------------------------------------------------
  // Bus, reset and verdict tasks
  // ----------------------------------------------------------------------------
  // No cycle limit here: a hung transfer is ended by the watchdog.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, exp, rdat)
  endtask

  // Reset is held 16 cycles and access waits two more, as the reset rules ask.
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (6000) @(posedge pclk);
    error_cnt++;
    give_verdict();
  end

  // ----------------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------------
  initial
  begin
    do_reset();
    rd(`USR_OFS_UREG, 32'h0, "ureg");
    rd(`USR_OFS_MODE, 32'h0, "mode");
    rd(`USR_OFS_INT_STAT, 32'h0, "stat rst");
    `CHK("stop", 1'b1, stop_mode)
    $display("test reset done");
    apb(1'b1, `USR_OFS_UREG, 32'h4);
    `CHK("en0", 2'b01, {e1, e0})
    apb(1'b1, `USR_OFS_UREG, 32'h8);
    `CHK("en1", 2'b10, {far.en_1, far.en_0})
    $display("test enable done");
    apb(1'b1, `USR_OFS_INT_MASK, 32'h1);
    rd(`USR_OFS_INT_MASK, 32'h1, "mask");
    // One cycle short of the qualification count must not latch; the full count must.
    far.pulse(0, 3);
    repeat (8) @(posedge pclk);
    rd(`USR_OFS_UREG, 32'h8, "short");
    `CHK("irq short", 1'b0, irq)
    far.pulse(0, 4);
    repeat (8) @(posedge pclk);
    rd(`USR_OFS_UREG, 32'h9, "sense0 latched");
    `CHK("irq", 1'b1, irq)
    rd(`USR_OFS_INT_STAT, 32'h1, "stat");
    rd(`USR_OFS_INT_STAT, 32'h0, "stat clr");
    `CHK("irq clr", 1'b0, irq)
    $display("test sense done");
    apb(1'b1, `USR_OFS_UREG, 32'h9);
    rd(`USR_OFS_UREG, 32'h9, "wr one");
    apb(1'b1, `USR_OFS_UREG, 32'h8);
    rd(`USR_OFS_UREG, 32'h8, "wr zero");
    far.level(1, 1'b1);
    repeat (10) @(posedge pclk);
    apb(1'b1, `USR_OFS_UREG, 32'h0);
    repeat (8) @(posedge pclk);
    rd(`USR_OFS_UREG, 32'h2, "set wins");
    `CHK("irq masked", 1'b0, irq)
    rd(`USR_OFS_INT_STAT, 32'h2, "stat1");
    far.level(1, 1'b0);
    repeat (4) @(posedge pclk);
    apb(1'b1, `USR_OFS_UREG, 32'h4);
    rd(`USR_OFS_UREG, 32'h4, "sense1 clr");
    $display("test clear done");
    apb(1'b1, `USR_OFS_MODE, 32'h1);
    `CHK("run", 1'b0, stop_mode)
    apb(1'b0, 12'h0f0, 32'h0);
    `CHK("slverr", 1'b1, rerr)
    `CHK("refused data", 32'h0, rdat)
    do_reset();
    `CHK("rst pins", 3'b100, {stop_mode, e1, e0})
    rd(`USR_OFS_MODE, 32'h0, "mode rst");
    rd(`USR_OFS_UREG, 32'h0, "ureg rst");
    $display("test midrun reset done");
    give_verdict();
  end
endmodule
